// [include/cdm_pkg.sv]
// cdm_pkg: shared constants and carriers for the capacitive detect block
// assumes a 250 MHz core clock and an Avalon-MM register master
package cdm_pkg;
  // -------------------------------------------------------------------
  // register map (word byte addresses)
  // -------------------------------------------------------------------
  localparam logic [5:0] CDM_ADDR_CFG = 6'h00;
  localparam logic [5:0] CDM_ADDR_LEVELS = 6'h04;
  localparam logic [5:0] CDM_ADDR_CMD = 6'h08;
  localparam logic [5:0] CDM_ADDR_SAMPLE = 6'h0c;
  localparam logic [5:0] CDM_ADDR_STATUS = 6'h10;
  localparam logic [5:0] CDM_ADDR_STORED = 6'h14;
  localparam logic [5:0] CDM_ADDR_REF = 6'h18;
  // cfg field positions
  localparam int CDM_CFG_HB = 0;
  localparam int CDM_CFG_SD = 1;
  localparam int CDM_CFG_DM = 2;
  localparam int CDM_CFG_BG = 3;
  localparam int CDM_CFG_POL = 4;
  localparam int CDM_CFG_SC_LO = 8;
  // levels field positions
  localparam int CDM_LVL_HYS_LO = 8;
  // cmd bits
  localparam int CDM_CMD_CAL = 0;
  localparam int CDM_CMD_MODTO = 1;
  localparam int CDM_CMD_DRIFT = 2;
  localparam int CDM_CMD_DRIFT_DN = 3;
  // reset values
  localparam logic [7:0] CDM_THR_RST = 8'h06;
  localparam logic [7:0] CDM_HYS_RST = 8'h02;
  // float time before each burst while the float is allowed
  localparam int CDM_FLOAT_NS = 15000;
  localparam int CDM_CLK_NS = 4;
  localparam int CDM_FLOAT_CYC = CDM_FLOAT_NS / CDM_CLK_NS;
  localparam logic [31:0] CDM_UNMAPPED = 32'hdeadbeef;

  typedef enum logic [1:0]
  {
    CDM_IDLE = 2'b00,
    CDM_FLOAT = 2'b01,
    CDM_EVAL = 2'b10
  } cdm_phase_e;

  typedef struct packed
  {
    logic health_pulse_enable; // 1 keeps the pre-burst float
    logic sense_direction; // 0 positive, 1 negative
    logic detect_mode_select; // 0 background, 1 learned threshold
    logic background_mode; // 0 volatile, 1 stored
    logic active_high; // output polarity
    logic [7:0] sleep_cycle_count;
    logic [7:0] detect_level;
    logic [7:0] release_margin;
  } cdm_cfg_s;

  typedef struct packed
  {
    logic [5:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } cdm_av_req_s;

  typedef struct packed
  {
    logic [31:0] readdata;
    logic waitrequest;
  } cdm_av_rsp_s;

  // nonvolatile store request towards the setup memory
  typedef struct packed
  {
    logic strobe;
    logic [15:0] value;
  } cdm_nv_s;
endpackage : cdm_pkg

// [design/cdm_detect.sv]
// cdm_detect: detection and calibration control for one sense channel
// assumes signal samples arrive once per burst, synchronous to core_clk,
// and an external nonvolatile store that accepts one-cycle write strobes
//
// What this block does
// - health float about 15 us before burst
// - health indicator enabled after reset
// - disable float only when sleep count zero
// - signal grows with burst length
// - sense direction selects load rise or fall
// - positive: activate past threshold, release past margin
// - negative: activate past threshold, release past margin
// - mode select: background or learned; volatile/stored
// - background levels offset from captured reference
// - direction picks side of reference for levels
// - output polarity independent of direction
// - volatile: calibrate at powerup or pin, calibration never stored
// - volatile: timeout and drift run normally
// - stored: pin calibration stores; powerup reloads
// - stored: drift adjusts reference, never stored
// - stored: timeout recalibration stores reference
// - stored reference loadable as number
// - learned: calibration stores present signal
// - learned: margin placed per direction
// - learned: no reference, drift, timeout; fixed
// - learned threshold loadable as number
// - detect at threshold reached, end below margin
// - zero margin releases at threshold
//
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`default_nettype none
module cdm_detect
  import cdm_pkg::*;
#(
  parameter int SIG_W = 16,
  parameter int FLOAT_CYC = CDM_FLOAT_CYC
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register bus
  input wire cdm_pkg::cdm_av_req_s av_req,
  output cdm_pkg::cdm_av_rsp_s av_rsp,
  // burst acquisition
  input wire logic burst_pending,
  input wire logic sample_valid,
  input wire logic [SIG_W-1:0] sample_value,
  output logic burst_go,
  // calibrate pin, synchronous, active low
  input wire logic calibrate_clear_n,
  // nonvolatile store
  input wire logic [SIG_W-1:0] nv_stored_value,
  output cdm_pkg::cdm_nv_s nv_wr,
  // detection output pin
  output logic out_o,
  output logic out_oe
);
  import cdm_pkg::*;

  // refuse widths and float lengths the counter and checks cannot serve
  if (SIG_W != 16 || FLOAT_CYC < 8 || FLOAT_CYC > 4096)
  begin : g_bad_param
    $error("cdm_detect: unsupported parameters");
  end

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef struct packed
  {
    cdm_cfg_s cfg;
    cdm_phase_e phase;
    logic [11:0] float_cnt;
    logic [15:0] ref_level; // background reference or learned threshold
    logic [15:0] last_sample;
    logic detect;
    logic boot; // powerup action pending
    logic cal_req;
    logic cal_store;
    logic cal_pin_q;
    cdm_nv_s nv;
    cdm_av_rsp_s rsp;
    logic out;
    logic oe;
    logic go;
  } cdm_state_s;

  cdm_state_s st_reg;
  cdm_state_s st_next;

  logic [16:0] thr_lvl;
  logic [16:0] rel_lvl;
  logic hit;
  logic release_ok;
  logic float_allowed;
  logic [15:0] samp;

  // -------------------------------------------------------------------
  // level computation
  // -------------------------------------------------------------------
  // levels carry one extra bit so upward offsets cannot wrap; offsets below zero still wrap
  always_comb
  begin
    samp = sample_value;
    thr_lvl = {1'b0, st_reg.ref_level};
    rel_lvl = {1'b0, st_reg.ref_level};
    if (!st_reg.cfg.detect_mode_select)
    begin
      // background: levels offset from reference
      if (!st_reg.cfg.sense_direction)
      begin
        // load rise lowers signal, so levels sit below
        thr_lvl = {1'b0, st_reg.ref_level} - 17'(st_reg.cfg.detect_level);
        rel_lvl = thr_lvl + 17'(st_reg.cfg.release_margin);
      end
      else
      begin
        thr_lvl = {1'b0, st_reg.ref_level} + 17'(st_reg.cfg.detect_level);
        rel_lvl = thr_lvl - 17'(st_reg.cfg.release_margin);
      end
    end
    else if (!st_reg.cfg.sense_direction)
      rel_lvl = thr_lvl + 17'(st_reg.cfg.release_margin);
    else
      rel_lvl = thr_lvl - 17'(st_reg.cfg.release_margin);
    // positive: smaller signal means more load; negative: larger signal means more load
    if (!st_reg.cfg.sense_direction)
    begin
      hit = {1'b0, samp} <= thr_lvl;
      release_ok = {1'b0, samp} > rel_lvl;
    end
    else
    begin
      hit = {1'b0, samp} >= thr_lvl;
      release_ok = {1'b0, samp} < rel_lvl;
    end
  end

  // float may be suppressed only with no sleep cycles
  assign float_allowed = st_reg.cfg.health_pulse_enable
    || (st_reg.cfg.sleep_cycle_count != 8'h00);

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb
  begin
    logic cal_new; // calibration requested in this cycle
    cal_new = 1'b0;
    st_next = st_reg;
    st_next.nv.strobe = 1'b0;
    st_next.go = 1'b0;
    st_next.rsp.waitrequest = 1'b1;
    st_next.rsp.readdata = '0;
    st_next.cal_pin_q = calibrate_clear_n;
    // first burst after reset: stored modes reload, volatile recalibrates;
    // waiting for it lets the setup be written before the mode is read
    if (st_reg.boot && burst_pending)
    begin
      st_next.boot = 1'b0;
      if (!st_reg.cfg.detect_mode_select && st_reg.cfg.background_mode)
        st_next.ref_level = nv_stored_value;
      else if (st_reg.cfg.detect_mode_select)
        st_next.ref_level = nv_stored_value;
      else
        st_next.cal_req = 1'b1;
    end
    // falling edge of the pin requests a calibration
    if (st_reg.cal_pin_q && !calibrate_clear_n)
    begin
      cal_new = 1'b1;
      st_next.cal_req = 1'b1;
      st_next.cal_store = st_reg.cfg.detect_mode_select
        || st_reg.cfg.background_mode;
    end
    // register bus, one wait cycle then answer
    if ((av_req.read || av_req.write) && st_reg.rsp.waitrequest)
    begin
      st_next.rsp.waitrequest = 1'b0;
      if (av_req.write)
      begin
        unique case (av_req.address)
          CDM_ADDR_CFG:
          begin
            st_next.cfg.health_pulse_enable =
              !av_req.writedata[CDM_CFG_HB];
            st_next.cfg.sense_direction = av_req.writedata[CDM_CFG_SD];
            st_next.cfg.detect_mode_select = av_req.writedata[CDM_CFG_DM];
            st_next.cfg.background_mode = av_req.writedata[CDM_CFG_BG];
            st_next.cfg.active_high = av_req.writedata[CDM_CFG_POL];
            st_next.cfg.sleep_cycle_count =
              av_req.writedata[CDM_CFG_SC_LO +: 8];
          end
          CDM_ADDR_LEVELS:
          begin
            st_next.cfg.detect_level = av_req.writedata[7:0];
            st_next.cfg.release_margin =
              av_req.writedata[CDM_LVL_HYS_LO +: 8];
          end
          CDM_ADDR_CMD:
          begin
            if (av_req.writedata[CDM_CMD_CAL])
            begin
              cal_new = 1'b1;
              st_next.cal_req = 1'b1;
              st_next.cal_store = st_reg.cfg.detect_mode_select
                || st_reg.cfg.background_mode;
            end
            // timeout recalibration, background modes only
            if (av_req.writedata[CDM_CMD_MODTO]
                && !st_reg.cfg.detect_mode_select)
            begin
              cal_new = 1'b1;
              st_next.cal_req = 1'b1;
              st_next.cal_store = st_reg.cfg.background_mode;
            end
            // drift step on the reference, never stored
            if (av_req.writedata[CDM_CMD_DRIFT]
                && !st_reg.cfg.detect_mode_select)
              st_next.ref_level = av_req.writedata[CDM_CMD_DRIFT_DN]
                ? st_reg.ref_level - 16'h0001
                : st_reg.ref_level + 16'h0001;
          end
          CDM_ADDR_REF:
          begin
            // numeric load of reference or learned threshold
            st_next.ref_level = av_req.writedata[15:0];
            st_next.nv.value = av_req.writedata[15:0];
            st_next.nv.strobe = 1'b1;
          end
          default:
          begin
          end
        endcase
      end
      else
      begin
        unique case (av_req.address)
          CDM_ADDR_CFG:
            st_next.rsp.readdata = {16'h0000,
              st_reg.cfg.sleep_cycle_count, 3'b000,
              st_reg.cfg.active_high, st_reg.cfg.background_mode,
              st_reg.cfg.detect_mode_select, st_reg.cfg.sense_direction,
              !st_reg.cfg.health_pulse_enable};
          CDM_ADDR_LEVELS:
            st_next.rsp.readdata = {16'h0000,
              st_reg.cfg.release_margin, st_reg.cfg.detect_level};
          CDM_ADDR_CMD:
            st_next.rsp.readdata = '0;
          CDM_ADDR_SAMPLE:
            st_next.rsp.readdata = {16'h0000, st_reg.last_sample};
          CDM_ADDR_STATUS:
            st_next.rsp.readdata = {29'h0, st_reg.cal_req,
              float_allowed, st_reg.detect};
          CDM_ADDR_STORED:
            st_next.rsp.readdata = {16'h0000, nv_stored_value};
          CDM_ADDR_REF:
            st_next.rsp.readdata = {16'h0000, st_reg.ref_level};
          default:
            st_next.rsp.readdata = CDM_UNMAPPED;
        endcase
      end
    end
    // burst sequencing with the pre-burst float
    unique case (st_reg.phase)
      CDM_IDLE:
        if (burst_pending)
        begin
          if (float_allowed)
          begin
            st_next.phase = CDM_FLOAT;
            st_next.float_cnt = 12'(FLOAT_CYC - 1);
            st_next.oe = 1'b0;
          end
          else
          begin
            st_next.phase = CDM_EVAL;
            st_next.go = 1'b1;
          end
        end
      CDM_FLOAT:
        if (st_reg.float_cnt == 12'h000)
        begin
          st_next.oe = 1'b1;
          st_next.go = 1'b1;
          st_next.phase = CDM_EVAL;
        end
        else
          st_next.float_cnt = st_reg.float_cnt - 12'h001;
      CDM_EVAL:
        if (sample_valid)
        begin
          st_next.phase = CDM_IDLE;
          st_next.last_sample = samp;
          if (st_reg.cal_req)
          begin
            // capture ends any detection
            // a request in this very cycle stays pending
            if (!cal_new)
            begin
              st_next.cal_req = 1'b0;
              st_next.cal_store = 1'b0;
            end
            st_next.ref_level = samp;
            st_next.detect = 1'b0;
            st_next.nv.strobe = st_reg.cal_store;
            st_next.nv.value = samp;
          end
          else if (!st_reg.detect && hit)
            st_next.detect = 1'b1;
          else if (st_reg.detect && release_ok)
            st_next.detect = 1'b0;
        end
      default:
        st_next.phase = CDM_IDLE;
    endcase
    st_next.out = st_next.detect ~^ st_next.cfg.active_high;
  end

  // -------------------------------------------------------------------
  // state register
  // -------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_reg <= '0;
      st_reg.cfg.health_pulse_enable <= 1'b1;
      st_reg.cfg.detect_level <= CDM_THR_RST;
      st_reg.cfg.release_margin <= CDM_HYS_RST;
      st_reg.phase <= CDM_IDLE;
      st_reg.boot <= 1'b1;
      st_reg.cal_pin_q <= 1'b1;
      st_reg.rsp.waitrequest <= 1'b1;
      st_reg.out <= 1'b1; // inactive, active low by default
      st_reg.oe <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  assign av_rsp = st_reg.rsp;
  assign nv_wr = st_reg.nv;
  assign out_o = st_reg.out;
  assign out_oe = st_reg.oe;
  assign burst_go = st_reg.go;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  sequence float_start;
    st_reg.phase == CDM_IDLE && burst_pending && float_allowed;
  endsequence

  chk_float_len: assert property (@(posedge core_clk) disable iff (!nrst)
    float_start |=> !out_oe [*8])
    else $error("float ended early");
  chk_float_go: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(burst_go) && st_reg.phase == CDM_EVAL && $past(st_reg.phase)
    == CDM_FLOAT |-> out_oe)
    else $error("burst started while floating");
  chk_hb_lock: assert property (@(posedge core_clk) disable iff (!nrst)
    st_reg.phase == CDM_IDLE && burst_pending
    && st_reg.cfg.sleep_cycle_count != 8'h00 |=> !out_oe)
    else $error("float disabled with sleep cycles");
  chk_out_pol: assert property (@(posedge core_clk) disable iff (!nrst)
    out_o == (st_reg.detect ~^ st_reg.cfg.active_high))
    else $error("output polarity wrong");
  chk_cal_store: assert property (@(posedge core_clk) disable iff (!nrst)
    st_reg.phase == CDM_EVAL && sample_valid && st_reg.cal_req
    && !st_reg.cfg.detect_mode_select && !st_reg.cfg.background_mode
    && !(av_req.write && av_req.address == CDM_ADDR_REF)
    |=> !nv_wr.strobe)
    else $error("volatile reference stored");
  chk_cal_obj: assert property (@(posedge core_clk) disable iff (!nrst)
    st_reg.phase == CDM_EVAL && sample_valid && st_reg.cal_req
    && st_reg.cal_store |=> nv_wr.strobe && nv_wr.value
    == $past(sample_value) && st_reg.ref_level == nv_wr.value)
    else $error("calibration not stored");
  chk_det_set: assert property (@(posedge core_clk) disable iff (!nrst)
    st_reg.phase == CDM_EVAL && sample_valid && !st_reg.cal_req
    && !st_reg.detect && hit |=> st_reg.detect)
    else $error("detection missed");
  chk_det_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    st_reg.phase == CDM_EVAL && sample_valid && !st_reg.cal_req
    && st_reg.detect && !release_ok |=> st_reg.detect)
    else $error("released inside margin");
  chk_bus_ans: assert property (@(posedge core_clk) disable iff (!nrst)
    av_req.read && av_rsp.waitrequest |=> !av_rsp.waitrequest)
    else $error("bus answer late");
endmodule : cdm_detect
`default_nettype wire

// [verif/cdm_far_model.sv]
// cdm_far_model: sense electrode, setup memory and host reading the pin
// assumes burst_go and nv_wr come from cdm_detect on core_clk
`default_nettype none
module cdm_far_model
  import cdm_pkg::*;
#(
  parameter logic [15:0] NV_INIT = 16'h0100
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // scenario control
  input wire logic [15:0] load_value,
  input wire logic slow,
  // burst answer
  input wire logic burst_go,
  output logic sample_valid,
  output logic [15:0] sample_value,
  // setup memory
  input wire cdm_pkg::cdm_nv_s nv_wr,
  output logic [15:0] nv_stored_value,
  // host view of the output pin
  input wire logic out_o,
  input wire logic out_oe,
  output logic pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_reg;
  logic busy_reg;
  logic last_reg;
  // one sample per burst, after a short or long burst
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_reg <= 1'b0;
      wait_reg <= 4'h0;
      sample_valid <= 1'b0;
      sample_value <= 16'h0;
      last_reg <= 1'b1;
    end
    else
    begin
      sample_valid <= 1'b0;
      sample_value <= ~sample_value; // no stale value between bursts
      if (burst_go)
      begin
        busy_reg <= 1'b1;
        wait_reg <= slow ? 4'h6 : 4'h1;
      end
      else if (busy_reg && wait_reg != 4'h0)
        wait_reg <= wait_reg - 4'h1;
      else if (busy_reg)
      begin
        busy_reg <= 1'b0;
        sample_valid <= 1'b1;
        sample_value <= load_value;
      end
      if (out_oe)
        last_reg <= out_o;
    end
  end
  // setup memory is nonvolatile: it keeps its content through reset
  initial
  begin
    nv_stored_value = NV_INIT;
  end
  always @(posedge core_clk)
    if (nv_wr.strobe === 1'b1)
      nv_stored_value <= nv_wr.value;
  // a floated pin does not keep its last level
  assign pin_level = out_oe ? out_o : ~last_reg;
endmodule // cdm_far_model
`default_nettype wire

// [verif/tb_cdm_detect.sv]
// tb_cdm_detect: self-checking bench for the capacitive detect block
// assumes cdm_pkg and the far-side model; float shortened to 9 cycles
`default_nettype none
module tb_cdm_detect;
  import cdm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FLOAT_C = 9;
  logic core_clk, nrst, burst_pending, sample_valid, burst_go;
  logic calibrate_clear_n, out_o, out_oe, slow, pin_level;
  logic [15:0] sample_value, nv_stored_value, load_value;
  cdm_av_req_s av_req;
  cdm_av_rsp_s av_rsp;
  cdm_nv_s nv_wr;
  int fail_count = 0;
  int cmp_count = 0;
  int nv_cnt = 0;
  int fl;
  logic lv;
  logic [31:0] q;
  // ----------------------------------------------------------------
  // instances
  // ----------------------------------------------------------------
  cdm_detect #(.SIG_W(16), .FLOAT_CYC(FLOAT_C)) i_cdm_detect (
    .core_clk(core_clk), .nrst(nrst), .av_req(av_req), .av_rsp(av_rsp),
    .burst_pending(burst_pending), .sample_valid(sample_valid),
    .sample_value(sample_value), .burst_go(burst_go),
    .calibrate_clear_n(calibrate_clear_n),
    .nv_stored_value(nv_stored_value), .nv_wr(nv_wr),
    .out_o(out_o), .out_oe(out_oe));
  cdm_far_model i_cdm_far_model (
    .core_clk(core_clk), .nrst(nrst), .load_value(load_value),
    .slow(slow), .burst_go(burst_go), .sample_valid(sample_valid),
    .sample_value(sample_value), .nv_wr(nv_wr),
    .nv_stored_value(nv_stored_value), .out_o(out_o), .out_oe(out_oe),
    .pin_level(pin_level));
  // clock and store-write counter
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
    if (nv_wr.strobe === 1'b1)
      nv_cnt <= nv_cnt + 1;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk_word(input string what, input logic [31:0] exp,
                          input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_pin(input string what, input logic exp,
                         input logic got);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask
  // one bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    @(posedge core_clk);
    av_req <= '{address: a, read: !wr, write: wr, writedata: d};
    do
      @(posedge core_clk);
    while (av_rsp.waitrequest !== 1'b0);
    rd = av_rsp.readdata;
    av_req <= '0;
  endtask
  function automatic logic [31:0] cfgw(input logic hbd, sd, dm, bg, pol,
                                       input logic [7:0] sc);
    cfgw = 32'h0;
    cfgw[CDM_CFG_HB] = hbd;
    cfgw[CDM_CFG_SD] = sd;
    cfgw[CDM_CFG_DM] = dm;
    cfgw[CDM_CFG_BG] = bg;
    cfgw[CDM_CFG_POL] = pol;
    cfgw[CDM_CFG_SC_LO +: 8] = sc;
  endfunction
  // one burst: counts floated cycles and returns the pin level after it
  task automatic burst(input logic [15:0] v, output int f, output logic l);
    int n;
    n = 0;
    f = 0;
    load_value <= v;
    @(posedge core_clk);
    burst_pending <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
      if (out_oe === 1'b0)
        f++;
    end
    while (burst_go !== 1'b1 && n < 200);
    burst_pending <= 1'b0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (sample_valid !== 1'b1 && n < 400);
    @(posedge core_clk);
    l = pin_level;
    repeat (2) @(posedge core_clk);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    bus(0, CDM_ADDR_CFG, 0, q);
    chk_word("cfg", 32'h0, q);
    bus(0, CDM_ADDR_LEVELS, 0, q);
    chk_word("levels", {16'h0, CDM_HYS_RST, CDM_THR_RST}, q);
    bus(0, CDM_ADDR_STATUS, 0, q);
    chk_pin("float enabled", 1'b1, q[1]);
    bus(0, 6'h3c, 0, q);
    chk_word("unmapped", CDM_UNMAPPED, q);
    chk_pin("out idle", 1'b1, pin_level);
    $display("test reset done");
  endtask
  task automatic t_float;
    int c0;
    c0 = nv_cnt;
    burst(16'd1000, fl, lv);
    chk_word("float cycles", FLOAT_C, fl);
    chk_word("volatile store", c0, nv_cnt);
    bus(1, CDM_ADDR_CFG, cfgw(1, 0, 0, 0, 0, 8'h00), q);
    bus(0, CDM_ADDR_STATUS, 0, q);
    chk_pin("float off", 1'b0, q[1]);
    burst(16'd1000, fl, lv);
    chk_word("no float", 0, fl);
    bus(1, CDM_ADDR_CFG, cfgw(1, 0, 0, 0, 0, 8'h05), q);
    bus(0, CDM_ADDR_STATUS, 0, q);
    chk_pin("float kept", 1'b1, q[1]);
    burst(16'd1000, fl, lv);
    chk_word("float sleep", FLOAT_C, fl);
    bus(1, CDM_ADDR_CFG, 32'h0, q);
    $display("test float done");
  endtask
  task automatic t_levels(input logic [31:0] cfg,
                          input logic [15:0] v [4], input logic [3:0] e);
    bus(1, CDM_ADDR_CFG, cfg, q);
    for (int i = 0; i < 4; i++)
    begin
      burst(v[i], fl, lv);
      chk_pin("out level", e[i], lv);
    end
  endtask
  task automatic t_bg;
    // reference 1000: positive detect at 994, release above 996
    t_levels(32'h0, '{16'd995, 16'd994, 16'd996, 16'd997}, 4'b1001);
    slow <= 1'b1;
    // negative, active high: detect at 1006, release below 1004
    t_levels(cfgw(0, 1, 0, 0, 1, 8'h00),
             '{16'd1005, 16'd1006, 16'd1004, 16'd1003}, 4'b0110);
    slow <= 1'b0;
    $display("test background done");
  endtask
  task automatic t_stored;
    int c0;
    bus(1, CDM_ADDR_CFG, cfgw(0, 0, 0, 1, 0, 8'h00), q);
    bus(1, CDM_ADDR_CMD, 32'h1 << CDM_CMD_CAL, q);
    c0 = nv_cnt;
    burst(16'd2000, fl, lv);
    chk_word("cal store", c0 + 1, nv_cnt);
    chk_word("cal value", 2000, nv_stored_value);
    burst(16'd1994, fl, lv);
    chk_pin("stored detect", 1'b0, lv);
    bus(1, CDM_ADDR_CMD, 32'h1 << CDM_CMD_DRIFT, q);
    burst(16'd1994, fl, lv);
    chk_word("drift store", c0 + 1, nv_cnt);
    bus(1, CDM_ADDR_CMD, 32'h1 << CDM_CMD_MODTO, q);
    burst(16'd1500, fl, lv);
    chk_word("timeout value", 1500, nv_stored_value);
    bus(1, CDM_ADDR_REF, 32'd3000, q);
    repeat (2) @(posedge core_clk);
    chk_word("loaded value", 3000, nv_stored_value);
    bus(0, CDM_ADDR_REF, 0, q);
    chk_word("ref readback", 3000, q);
    $display("test stored done");
  endtask
  task automatic t_learned;
    int c0;
    // positive direction, as level control with margin needs
    bus(1, CDM_ADDR_CFG, cfgw(0, 0, 1, 0, 0, 8'h00), q);
    bus(1, CDM_ADDR_LEVELS, 32'h0006, q);
    @(posedge core_clk);
    calibrate_clear_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    calibrate_clear_n <= 1'b1;
    burst(16'd500, fl, lv);
    chk_word("learned value", 500, nv_stored_value);
    burst(16'd500, fl, lv);
    chk_pin("learned detect", 1'b0, lv);
    burst(16'd501, fl, lv);
    chk_pin("zero margin", 1'b1, lv);
    bus(1, CDM_ADDR_REF, 32'd600, q);
    repeat (2) @(posedge core_clk);
    chk_word("loaded thr", 600, nv_stored_value);
    burst(16'd550, fl, lv);
    chk_pin("loaded detect", 1'b0, lv);
    bus(1, CDM_ADDR_CMD, 32'h1 << CDM_CMD_MODTO, q);
    c0 = nv_cnt;
    burst(16'd700, fl, lv);
    chk_word("no timeout", c0, nv_cnt);
    chk_pin("fixed release", 1'b1, lv);
    $display("test learned done");
  endtask
  task automatic t_boot;
    int c0;
    // reset in mid-run, then stored mode must reload the kept threshold
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    c0 = nv_cnt;
    bus(1, CDM_ADDR_CFG, cfgw(0, 0, 0, 1, 0, 8'h00), q);
    burst(16'd900, fl, lv);
    bus(0, CDM_ADDR_REF, 0, q);
    chk_word("boot reload", 600, q);
    chk_word("boot no store", c0, nv_cnt);
    chk_pin("boot idle", 1'b1, lv);
    $display("test boot done");
  endtask
  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #200000;
    fail_count++;
    complete_run();
  end
  initial
  begin
    nrst = 1'b0;
    av_req = '0;
    burst_pending = 1'b0;
    calibrate_clear_n = 1'b1;
    load_value = 16'h0;
    slow = 1'b0;
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_float();
    t_bg();
    t_stored();
    t_learned();
    t_boot();
    complete_run();
  end
endmodule // tb_cdm_detect
`default_nettype wire
